// ---- verilog/link_framer_regs.vh ----
/*
  Register offsets, command values, reset values and rate limits of the
  serial link setup and framer block.
  Assumes inclusion by bare name from the design files; definitions only.
*/
`ifndef LINK_FRAMER_REGS_VH
`define LINK_FRAMER_REGS_VH

// Register offsets (15-bit control-port address)
`define OFS_SOFT_RESET     15'h0000
`define OFS_DP_RESET       15'h0001
`define OFS_POWER_MODE     15'h0002
`define OFS_BW_MODE        15'h0200
`define OFS_DECIMATION     15'h0201
`define OFS_RATE_BAND      15'h056e
`define OFS_QUICK_CFG      15'h0570
`define OFS_LINK_CTRL      15'h0571
`define OFS_CS_WORD        15'h058b
`define OFS_SUBCLASS_RES   15'h058f
`define OFS_SER_PLL_CAL    15'h1222
`define OFS_STARTUP_CTRL   15'h1228
`define OFS_LOL_CLEAR      15'h1262

// Reset values
`define RST_ZERO           8'h00
`define RST_RATE_BAND      8'h00
`define RST_LINK_CTRL      8'h14

// Command values that restart the converter or the link
`define VAL_SOFT_RESET     8'h81
`define VAL_DP_RESET       8'h02
`define VAL_LINK_PD        8'h15
`define VAL_LINK_PU        8'h14

// Four-times packing mode set
`define VAL_FS4_QUICK      8'hfe
`define VAL_FS4_CS_WORD    8'h0f
`define VAL_FS4_SUBCLASS   8'h2f
`define VAL_FULL_BW        8'h00

// Start-up write sequence, seven steps
`define VAL_STARTUP_RST    8'h4f
`define VAL_STARTUP_RUN    8'h0f
`define VAL_PLL_NORMAL     8'h00
`define VAL_PLL_CAL_RST    8'h04
`define VAL_LOL_CLR        8'h08
`define VAL_LOL_NORMAL     8'h00
`define INIT_LAST_STEP     3'd6

// Lane-rate band codes
`define BAND_MID           8'h00
`define BAND_LOW           8'h10
`define BAND_HIGH          8'h30
`define BAND_LOWEST        8'h50

// Lane-rate limits and band edges in Mbps
`define RATE_MIN_MBPS      32'd3400
`define RATE_MAX_MBPS      32'd16000
`define RATE_EDGE_LO_MBPS  32'd3375
`define RATE_EDGE_MID_MBPS 32'd6750
`define RATE_EDGE_HI_MBPS  32'd13500

// Link word size and 8b/10b factor
`define NPRIME_TIMES_10    32'd160
`define OCTET_BITS         32'd8

// Field limits and samples per frame
`define N_MIN_CODE         5'd7
`define N_MAX_CODE         5'd15
`define FS4_SAMPLES        3'd5
`define STD_SAMPLES        3'd4

// Control-port frame lengths
`define SPI_INSTR_BITS     5'd16
`define SPI_FRAME_BITS     5'd24

`endif

// ---- verilog/frame_pair_buffer.v ----
/*
  Two-entry frame buffer with valid/ready on both sides and a flush.
  Assumes one clock; flush drops all held frames.
*/
`timescale 1ns/1ps
`default_nettype none

module frame_pair_buffer (
  // Clock and reset
  input  wire        clk_sys,
  input  wire        rstn,
  input  wire        flush,
  // Fill side
  input  wire        in_valid,
  output wire        in_ready,
  input  wire [63:0] in_data,
  // Drain side
  output wire        out_valid,
  input  wire        out_ready,
  output wire [63:0] out_data,
  // Occupancy
  output wire [1:0]  count
);

  reg [63:0] mem_q [0:1];
  reg        wr_ptr_q;
  reg        rd_ptr_q;
  reg [1:0]  cnt_q;
  wire       push = in_valid && in_ready;
  wire       pop  = out_valid && out_ready;

  assign in_ready  = (cnt_q != 2'd2);
  assign out_valid = (cnt_q != 2'd0);
  assign out_data  = mem_q[rd_ptr_q];
  assign count     = cnt_q;

  always @(posedge clk_sys) begin
    if (!rstn || flush) begin
      wr_ptr_q <= 1'b0;
      rd_ptr_q <= 1'b0;
      cnt_q    <= 2'd0;
    end else begin
      if (push)
        wr_ptr_q <= ~wr_ptr_q;
      if (pop)
        rd_ptr_q <= ~rd_ptr_q;
      if (push && !pop)
        cnt_q <= cnt_q + 2'd1;
      else if (pop && !push)
        cnt_q <= cnt_q - 2'd1;
    end
  end

  // Storage needs no reset; occupancy guards every read
  always @(posedge clk_sys) begin
    if (push)
      mem_q[wr_ptr_q] <= in_data;
  end

endmodule // frame_pair_buffer

`default_nettype wire

// ---- verilog/serial_link_setup_framer.v ----
/*
  Transmit-side link setup and framer of a dual converter: control-port
  registers, restart and start-up sequence tracking, lane-rate checks,
  and sample packing into 64-bit frames spread over eight lanes.
  Assumes all inputs synchronous to clk_sys and the serial clock slower
  than a quarter of clk_sys.
*/
// Functional notes
// - Four-times mode packs five 12-bit samples per frame
// - Four-times mode runs L8 M2 F2 S4 N16
// - Four-times mode needs full-bandwidth mode selected
// - All eight lanes form one link
// - Lane rate at most 16 Gbps
// - Lane rate from M, N', L, output rate
// - Only listed L/F/S/HD combinations supported
// - M counts virtual converters
// - Four lane-rate band codes accepted
`timescale 1ns/1ps
`default_nettype none
`include "link_framer_regs.vh"

module serial_link_setup_framer #(
  parameter [15:0] ADC_CLK_MHZ = 16'd2000
) (
  // Clock and reset
  input  wire        clk_sys,
  input  wire        rstn,
  // Serial control port
  input  wire        spi_cs_n,
  input  wire        spi_sclk,
  input  wire        spi_sdio_in,
  output reg         spi_sdio_out,
  output reg         spi_sdio_oe,
  // Power-down pin
  input  wire        power_down_pin,
  // Sample stream in
  input  wire        samp_valid,
  output reg         samp_ready,
  input  wire [15:0] samp_data,
  // Frames to the lanes
  output reg         lane_valid,
  input  wire        lane_ready,
  output reg  [63:0] serial_lane_output,
  // Status
  output reg         fs4_active,
  output reg         reinit_required,
  output reg         config_error,
  output reg         lane_rate_ok,
  output reg         band_mismatch
);

  // Control-port shift logic
  reg        sclk_prev_q;
  reg [4:0]  bit_cnt_q;
  reg [23:0] shift_q;
  reg        rd_q;
  reg [7:0]  rdata_q;
  reg        wr_en_q;
  reg [14:0] wr_addr_q;
  reg [7:0]  wr_data_q;
  reg [7:0]  rd_mux;
  wire        sclk_rise = !spi_cs_n && spi_sclk && !sclk_prev_q;
  wire        sclk_fall = !spi_cs_n && !spi_sclk && sclk_prev_q;
  wire [23:0] shift_d   = {shift_q[22:0], spi_sdio_in};
  // Registers
  reg [7:0] soft_reset_control_q;
  reg [7:0] datapath_reset_control_q;
  reg [7:0] power_mode_control_q;
  reg [7:0] channel_bandwidth_mode_q;
  reg [7:0] decimation_ratio_select_q;
  reg [7:0] lane_rate_band_q;
  reg [7:0] link_mode_quick_config_q;
  reg [7:0] link_control_q;
  reg [7:0] control_bits_word_size_q;
  reg [7:0] subclass_resolution_q;
  reg [7:0] serializer_pll_cal_control_q;
  reg [7:0] link_startup_circuit_control_q;
  reg [7:0] loss_of_lock_clear_q;
  always @(posedge clk_sys) begin
    if (!rstn) begin
      sclk_prev_q  <= 1'b0;
      bit_cnt_q    <= 5'd0;
      shift_q      <= 24'h000000;
      rd_q         <= 1'b0;
      rdata_q      <= 8'h00;
      wr_en_q      <= 1'b0;
      wr_addr_q    <= 15'h0000;
      wr_data_q    <= 8'h00;
      spi_sdio_out <= 1'b0;
      spi_sdio_oe  <= 1'b0;
    end else begin
      sclk_prev_q <= spi_sclk;
      wr_en_q     <= 1'b0;
      if (spi_cs_n) begin
        bit_cnt_q   <= 5'd0;
        spi_sdio_oe <= 1'b0;
      end else if (sclk_rise && bit_cnt_q != `SPI_FRAME_BITS) begin
        shift_q   <= shift_d;
        bit_cnt_q <= bit_cnt_q + 5'd1;
        if (bit_cnt_q == `SPI_INSTR_BITS - 5'd1) begin
          rd_q      <= shift_d[15];
          wr_addr_q <= shift_d[14:0];
        end
        if (bit_cnt_q == `SPI_FRAME_BITS - 5'd1 && !rd_q) begin
          wr_en_q   <= 1'b1;
          wr_data_q <= shift_d[7:0];
        end
      end else if (sclk_fall) begin
        // Read data leaves on falling edges, MSB first
        if (rd_q && bit_cnt_q >= `SPI_INSTR_BITS && bit_cnt_q != `SPI_FRAME_BITS) begin
          spi_sdio_out <= (bit_cnt_q == `SPI_INSTR_BITS) ? rd_mux[7] : rdata_q[6];
          rdata_q      <= (bit_cnt_q == `SPI_INSTR_BITS) ? rd_mux : {rdata_q[6:0], 1'b0};
          spi_sdio_oe  <= 1'b1;
        end else begin
          spi_sdio_oe <= 1'b0;
        end
      end
    end
  end

  always @* begin
    case (wr_addr_q)
      `OFS_SOFT_RESET:   rd_mux = soft_reset_control_q;
      `OFS_DP_RESET:     rd_mux = datapath_reset_control_q;
      `OFS_POWER_MODE:   rd_mux = power_mode_control_q;
      `OFS_BW_MODE:      rd_mux = channel_bandwidth_mode_q;
      `OFS_DECIMATION:   rd_mux = decimation_ratio_select_q;
      `OFS_RATE_BAND:    rd_mux = lane_rate_band_q;
      `OFS_QUICK_CFG:    rd_mux = link_mode_quick_config_q;
      `OFS_LINK_CTRL:    rd_mux = link_control_q;
      `OFS_CS_WORD:      rd_mux = control_bits_word_size_q;
      `OFS_SUBCLASS_RES: rd_mux = subclass_resolution_q;
      `OFS_SER_PLL_CAL:  rd_mux = serializer_pll_cal_control_q;
      `OFS_STARTUP_CTRL: rd_mux = link_startup_circuit_control_q;
      `OFS_LOL_CLEAR:    rd_mux = loss_of_lock_clear_q;
      default:           rd_mux = 8'h00;
    endcase
  end
  // Write decode and restart events
  wire soft_rst = wr_en_q && wr_addr_q == `OFS_SOFT_RESET && wr_data_q == `VAL_SOFT_RESET;
  wire dp_rst   = wr_en_q && wr_addr_q == `OFS_DP_RESET && wr_data_q == `VAL_DP_RESET;
  wire pwr_up   = wr_en_q && wr_addr_q == `OFS_POWER_MODE && wr_data_q[1:0] == 2'b00 &&
                  power_mode_control_q[1:0] != 2'b00;
  wire link_cyc = wr_en_q && wr_addr_q == `OFS_LINK_CTRL && wr_data_q == `VAL_LINK_PU &&
                  link_control_q == `VAL_LINK_PD;
  reg  power_down_pin_prev_q;
  wire pin_up   = power_down_pin_prev_q && !power_down_pin;
  wire restart  = soft_rst || dp_rst || pwr_up || link_cyc || pin_up;
  wire cfg_wr   = wr_en_q && (wr_addr_q == `OFS_QUICK_CFG || wr_addr_q == `OFS_CS_WORD ||
                  wr_addr_q == `OFS_SUBCLASS_RES || wr_addr_q == `OFS_BW_MODE);
  wire flush    = restart || cfg_wr;
  always @(posedge clk_sys) begin
    if (!rstn || soft_rst) begin
      soft_reset_control_q           <= `RST_ZERO;
      datapath_reset_control_q       <= `RST_ZERO;
      power_mode_control_q           <= `RST_ZERO;
      channel_bandwidth_mode_q       <= `RST_ZERO;
      decimation_ratio_select_q      <= `RST_ZERO;
      lane_rate_band_q               <= `RST_RATE_BAND;
      link_mode_quick_config_q       <= `RST_ZERO;
      link_control_q                 <= `RST_LINK_CTRL;
      control_bits_word_size_q       <= `RST_ZERO;
      subclass_resolution_q          <= `RST_ZERO;
      serializer_pll_cal_control_q   <= `RST_ZERO;
      link_startup_circuit_control_q <= `RST_ZERO;
      loss_of_lock_clear_q           <= `RST_ZERO;
    end else if (wr_en_q) begin
      case (wr_addr_q)
        `OFS_DP_RESET:     datapath_reset_control_q       <= wr_data_q;
        `OFS_POWER_MODE:   power_mode_control_q           <= wr_data_q;
        `OFS_BW_MODE:      channel_bandwidth_mode_q       <= wr_data_q;
        `OFS_DECIMATION:   decimation_ratio_select_q      <= wr_data_q;
        `OFS_RATE_BAND:    lane_rate_band_q               <= wr_data_q;
        `OFS_QUICK_CFG:    link_mode_quick_config_q       <= wr_data_q;
        `OFS_LINK_CTRL:    link_control_q                 <= wr_data_q;
        `OFS_CS_WORD:      control_bits_word_size_q       <= wr_data_q;
        `OFS_SUBCLASS_RES: subclass_resolution_q          <= wr_data_q;
        `OFS_SER_PLL_CAL:  serializer_pll_cal_control_q   <= wr_data_q;
        `OFS_STARTUP_CTRL: link_startup_circuit_control_q <= wr_data_q;
        `OFS_LOL_CLEAR:    loss_of_lock_clear_q           <= wr_data_q;
        default:           soft_reset_control_q           <= soft_reset_control_q;
      endcase
    end
  end
  // Start-up write sequence tracker
  reg  [2:0]  step_q;
  reg  [14:0] exp_addr;
  reg  [7:0]  exp_data;
  always @* begin
    case (step_q)
      3'd0:    begin exp_addr = `OFS_STARTUP_CTRL; exp_data = `VAL_STARTUP_RST; end
      3'd1:    begin exp_addr = `OFS_STARTUP_CTRL; exp_data = `VAL_STARTUP_RUN; end
      3'd2:    begin exp_addr = `OFS_SER_PLL_CAL;  exp_data = `VAL_PLL_NORMAL;  end
      3'd3:    begin exp_addr = `OFS_SER_PLL_CAL;  exp_data = `VAL_PLL_CAL_RST; end
      3'd4:    begin exp_addr = `OFS_SER_PLL_CAL;  exp_data = `VAL_PLL_NORMAL;  end
      3'd5:    begin exp_addr = `OFS_LOL_CLEAR;    exp_data = `VAL_LOL_CLR;     end
      3'd6:    begin exp_addr = `OFS_LOL_CLEAR;    exp_data = `VAL_LOL_NORMAL;  end
      default: begin exp_addr = `OFS_STARTUP_CTRL; exp_data = `VAL_STARTUP_RST; end
    endcase
  end
  wire seq_hit  = wr_en_q && wr_addr_q == exp_addr && wr_data_q == exp_data;
  wire seq_addr = wr_en_q && (wr_addr_q == `OFS_STARTUP_CTRL || wr_addr_q == `OFS_SER_PLL_CAL ||
                  wr_addr_q == `OFS_LOL_CLEAR);
  wire seq_first = wr_en_q && wr_addr_q == `OFS_STARTUP_CTRL && wr_data_q == `VAL_STARTUP_RST;
  always @(posedge clk_sys) begin
    if (!rstn) begin
      power_down_pin_prev_q     <= 1'b0;
      step_q          <= 3'd0;
      reinit_required <= 1'b1;
    end else begin
      power_down_pin_prev_q <= power_down_pin;
      // A restart in the same cycle as the last step wins
      if (restart) begin
        step_q          <= 3'd0;
        reinit_required <= 1'b1;
      end else if (seq_hit && step_q == `INIT_LAST_STEP) begin
        step_q          <= 3'd0;
        reinit_required <= 1'b0;
      end else if (seq_hit) begin
        step_q <= step_q + 3'd1;
      end else if (seq_addr) begin
        // Out-of-order write restarts the walk
        step_q <= seq_first ? 3'd1 : 3'd0;
      end
    end
  end
  // Link configuration decode; M counts virtual converters
  wire fs4_cfg = link_mode_quick_config_q == `VAL_FS4_QUICK && control_bits_word_size_q == `VAL_FS4_CS_WORD &&
                 subclass_resolution_q == `VAL_FS4_SUBCLASS;
  wire fs4_ok  = fs4_cfg && channel_bandwidth_mode_q == `VAL_FULL_BW;
  wire [1:0] l_log = fs4_cfg ? 2'd3 : link_mode_quick_config_q[1:0];
  wire       m_two = fs4_cfg || link_mode_quick_config_q[2];
  wire [1:0] f_log = fs4_cfg ? 2'd1 : link_mode_quick_config_q[4:3];
  wire [4:0] n_code = subclass_resolution_q[4:0];
  reg        combo_ok;
  always @* begin
    if (fs4_cfg)
      combo_ok = 1'b1;
    else if (!m_two)
      combo_ok = f_log == 2'd1 || (f_log == 2'd0 && l_log != 2'd0) ||
                 (f_log == 2'd2 && l_log == 2'd0);
    else
      combo_ok = (l_log == 2'd0 && (f_log == 2'd2 || f_log == 2'd3)) ||
                 (l_log == 2'd1 && f_log == 2'd1);
  end
  wire cfg_bad = (fs4_cfg && !fs4_ok) || !combo_ok || n_code < `N_MIN_CODE || n_code > `N_MAX_CODE;
  // Lane rate in Mbps is bits_x / div_x; compared without division
  wire [7:0]  decimation_ratio    = (decimation_ratio_select_q == 8'h00) ? 8'h01 : decimation_ratio_select_q;
  wire [31:0] bits_x = (m_two ? 32'd2 : 32'd1) * `NPRIME_TIMES_10 * {16'h0000, ADC_CLK_MHZ};
  wire [31:0] div_x  = ({24'h000000, decimation_ratio} * `OCTET_BITS) << l_log;
  wire        below_min  = bits_x < `RATE_MIN_MBPS * div_x;
  wire        above_max  = bits_x > `RATE_MAX_MBPS * div_x;
  reg  [7:0]  band_exp;
  always @* begin
    if (bits_x < `RATE_EDGE_LO_MBPS * div_x)
      band_exp = `BAND_LOWEST;
    else if (bits_x < `RATE_EDGE_MID_MBPS * div_x)
      band_exp = `BAND_LOW;
    else if (bits_x < `RATE_EDGE_HI_MBPS * div_x)
      band_exp = `BAND_MID;
    else
      band_exp = `BAND_HIGH;
  end
  // Packer
  wire        run  = !power_down_pin && !link_control_q[0] && !cfg_bad;
  wire [2:0]  need = fs4_ok ? `FS4_SAMPLES : `STD_SAMPLES;
  reg  [2:0]  pk_cnt_q;
  reg  [63:0] acc_q;
  wire        take = samp_valid && samp_ready;
  wire [63:0] acc_d = fs4_ok ? {4'h0, acc_q[47:0], samp_data[15:4]} : {acc_q[47:0], samp_data};
  wire [63:0] frame = fs4_ok ? {acc_d[59:0], 4'h0} : acc_d;
  wire        push = take && pk_cnt_q == need - 3'd1;
  wire        buf_in_ready;
  wire        buf_valid;
  wire [63:0] buf_data;
  wire [1:0]  buf_cnt;
  wire        pop = buf_valid && (!lane_valid || lane_ready);
  wire [1:0]  cnt_next = buf_cnt + {1'b0, push && buf_in_ready} - {1'b0, pop};
  frame_pair_buffer u_buf (
    .clk_sys   (clk_sys),
    .rstn      (rstn),
    .flush     (flush),
    .in_valid  (push),
    .in_ready  (buf_in_ready),
    .in_data   (frame),
    .out_valid (buf_valid),
    .out_ready (!lane_valid || lane_ready),
    .out_data  (buf_data),
    .count     (buf_cnt)
  );
  always @(posedge clk_sys) begin
    if (!rstn || flush) begin
      pk_cnt_q           <= 3'd0;
      acc_q              <= 64'h0000000000000000;
      samp_ready         <= 1'b0;
      lane_valid         <= 1'b0;
      serial_lane_output <= 64'h0000000000000000;
    end else begin
      // Ready held low unless the buffer can take a frame next cycle
      samp_ready <= run && cnt_next != 2'd2;
      if (take) begin
        acc_q    <= acc_d;
        pk_cnt_q <= push ? 3'd0 : pk_cnt_q + 3'd1;
      end
      if (pop) begin
        lane_valid         <= 1'b1;
        serial_lane_output <= buf_data;
      end else if (lane_ready) begin
        lane_valid <= 1'b0;
      end
    end
  end
  always @(posedge clk_sys) begin
    if (!rstn) begin
      fs4_active    <= 1'b0;
      config_error  <= 1'b0;
      lane_rate_ok  <= 1'b0;
      band_mismatch <= 1'b0;
    end else begin
      fs4_active    <= fs4_ok;
      config_error  <= cfg_bad;
      lane_rate_ok  <= !below_min && !above_max;
      band_mismatch <= lane_rate_band_q != band_exp;
    end
  end
endmodule // serial_link_setup_framer

`default_nettype wire

// ---- bench/link_framer_props.sv ----
/* Port assertions for the link setup framer.
   Assumes a bind from the bench top file. */
`timescale 1ns/1ps
`default_nettype none
module link_framer_props (
  // Clock and reset
  input wire logic        clk_sys,
  input wire logic        rstn,
  // Pins and stream
  input wire logic        spi_cs_n,
  input wire logic        spi_sdio_oe,
  input wire logic        power_down_pin,
  input wire logic        samp_ready,
  input wire logic        lane_valid,
  input wire logic        lane_ready,
  input wire logic [63:0] serial_lane_output,
  // Status
  input wire logic        fs4_active,
  input wire logic        reinit_required,
  input wire logic        config_error
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  a_reset_state: assert property (disable iff (1'b0)
    !rstn |=> !lane_valid && !samp_ready && reinit_required) else $error("reset state wrong");
  a_frame_hold: assert property (
    lane_valid && !lane_ready |=> !lane_valid || $stable(serial_lane_output)) else $error("frame not held");
  a_spare_zero: assert property (
    fs4_active && lane_valid |-> serial_lane_output[3:0] == 4'h0) else $error("spare bits set");
  a_fs4_legal: assert property (
    fs4_active |-> !config_error) else $error("packing mode flagged");
  a_err_refuse: assert property (
    config_error |-> !samp_ready) else $error("sample taken in bad config");
  a_pd_refuse: assert property (
    power_down_pin |=> !samp_ready) else $error("sample taken in power down");
  a_pd_restart: assert property (
    $fell(power_down_pin) |-> ##[1:4] reinit_required) else $error("power up not flagged");
  a_oe_idle: assert property (
    spi_cs_n && $past(spi_cs_n) |-> !spi_sdio_oe) else $error("sdio driven while idle");
endmodule // link_framer_props
`default_nettype wire

// ---- bench/lane_receiver.sv ----
/* Frame receiver model for the eight-lane link.
   Assumes frames qualified by lane_valid and lane_ready. */
`timescale 1ns/1ps
`default_nettype none
module lane_receiver (
  // Clock
  input wire logic        clk_sys,
  // Link side
  input wire logic        lane_valid,
  output logic            lane_ready,
  input wire logic [63:0] serial_lane_output,
  // Bench side
  input wire logic        stall_en,
  output logic            got,
  output logic [63:0]     got_data
);
  logic [2:0] ph_q;
  initial begin
    {ph_q, lane_ready, got, got_data} = '0;
  end
  // Ready only one cycle in eight is slower than the sample side, so the buffer fills
  always @(posedge clk_sys) begin
    ph_q <= ph_q + 3'd1;
    lane_ready <= !stall_en || ph_q == 3'd7;
    got <= lane_valid && lane_ready;
    got_data <= serial_lane_output;
  end
endmodule // lane_receiver
`default_nettype wire

// ---- bench/serial_link_setup_framer_tb.sv ----
/* Self-checking bench for the link setup framer.
   Assumes the receiver model and the bound checker. */
`timescale 1ns/1ps
`default_nettype none
module serial_link_setup_framer_tb;
  logic        clk_sys, rstn, spi_cs_n, spi_sclk, spi_sdio_in, power_down_pin, samp_valid, stall_en;
  logic [15:0] samp_data;
  wire         spi_sdio_out, spi_sdio_oe, samp_ready, lane_valid, lane_ready, got;
  wire         fs4_active, reinit_required, config_error, lane_rate_ok, band_mismatch;
  wire  [63:0] serial_lane_output, got_data;
  logic [63:0] exp_q[$];
  logic [31:0] rnd;
  logic [7:0]  rd;
  int          err_count, n_tests, cyc;

  // Faster converter clock reaches the top lane-rate band
  serial_link_setup_framer #(.ADC_CLK_MHZ(16'd3200)) dut_u (.clk_sys, .rstn, .spi_cs_n, .spi_sclk,
    .spi_sdio_in, .spi_sdio_out, .spi_sdio_oe, .power_down_pin, .samp_valid, .samp_ready, .samp_data,
    .lane_valid, .lane_ready, .serial_lane_output, .fs4_active, .reinit_required, .config_error,
    .lane_rate_ok, .band_mismatch);
  lane_receiver rx_u (.clk_sys, .lane_valid, .lane_ready, .serial_lane_output, .stall_en, .got, .got_data);

  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction

  task automatic chk_bit(input string nm, input logic e, input logic g);
    n_tests++;
    if (g !== e) begin
      err_count++;
      $display("mismatch %s expected %b seen %b", nm, e, g);
    end
  endtask

  task automatic chk_word(input string nm, input logic [63:0] e, input logic [63:0] g);
    n_tests++;
    if (g !== e) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic test_done;
    $display("checks %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // Each sclk level held three cycles, above the two-cycle minimum
  task automatic spi(input logic r, input logic [14:0] a, input logic [7:0] d);
    logic [23:0] w;
    w = {r, a, d};
    spi_cs_n = 1'b0;
    for (int i = 23; i >= 0; i--) begin
      spi_sdio_in = w[i];
      repeat (3) @(negedge clk_sys);
      spi_sclk = 1'b1;
      repeat (3) @(negedge clk_sys);
      if (i < 8) rd[i] = spi_sdio_out;
      spi_sclk = 1'b0;
    end
    spi_cs_n = 1'b1;
    repeat (8) @(negedge clk_sys);
  endtask

  task automatic init_seq;
    logic [14:0] a [7] = '{15'h1228, 15'h1228, 15'h1222, 15'h1222, 15'h1222, 15'h1262, 15'h1262};
    logic [7:0]  v [7] = '{8'h4f, 8'h0f, 8'h00, 8'h04, 8'h00, 8'h08, 8'h00};
    for (int i = 0; i < 7; i++) begin
      spi(1'b0, a[i], v[i]);
      if (i == 5) chk_bit("reinit_six", 1'b1, reinit_required);
    end
    chk_bit("reinit_clear", 1'b0, reinit_required);
  endtask

  // Five samples make a packed frame, four a plain one; valid stays up for the caller to drop
  task automatic frames(input int n);
    logic [15:0] s [5];
    logic [63:0] f;
    f = '0;
    for (int i = 0; i < n; i++) begin
      rnd = lfsr(rnd);
      s[i] = rnd[15:0];
      f = (n == 5) ? {f[51:0], s[i][15:4]} : {f[47:0], s[i]};
    end
    exp_q.push_back((n == 5) ? {f[59:0], 4'h0} : f);
    for (int i = 0; i < n; i++) begin
      samp_data = s[i];
      samp_valid = 1'b1;
      do @(posedge clk_sys); while (samp_ready !== 1'b1);
      @(negedge clk_sys);
    end
  endtask

  always @(posedge clk_sys)
    if (got === 1'b1) chk_word("frame", exp_q.size() ? exp_q.pop_front() : 64'hx, got_data);

  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 40000) begin
      err_count++;
      test_done;
    end
  end

  initial begin
    logic [7:0]  dec [4] = '{8'h01, 8'h02, 8'h04, 8'h08};
    logic [7:0]  band [4] = '{8'h30, 8'h00, 8'h10, 8'h50};
    logic [14:0] ea [4] = '{15'h0001, 15'h0571, 15'h0002, 15'h0000};
    logic [7:0]  e1 [4] = '{8'h02, 8'h15, 8'h01, 8'h81};
    logic [7:0]  e2 [4] = '{8'h00, 8'h14, 8'h00, 8'h00};
    {spi_cs_n, spi_sclk, spi_sdio_in, power_down_pin, samp_valid, stall_en, rstn} = 7'b1000000;
    samp_data = 16'h0;
    rnd = 32'he6ef;
    repeat (12) @(negedge clk_sys);
    rstn = 1'b1;
    repeat (3) @(negedge clk_sys);
    chk_bit("reinit_rst", 1'b1, reinit_required);
    chk_bit("cfg_default", 1'b1, config_error);
    $display("test reset done");
    spi(1'b0, 15'h0570, 8'hfe);
    spi(1'b0, 15'h058b, 8'h0f);
    spi(1'b0, 15'h058f, 8'h2f);
    chk_bit("fs4", 1'b1, fs4_active);
    chk_bit("cfg_fs4", 1'b0, config_error);
    chk_bit("rate_max", 1'b1, lane_rate_ok);
    spi(1'b1, 15'h0570, 8'h00);
    chk_word("rd_quick", 64'hfe, {56'h0, rd});
    spi(1'b1, 15'h0003, 8'h00);
    chk_word("rd_unmapped", 64'h0, {56'h0, rd});
    spi(1'b0, 15'h0200, 8'h01);
    chk_bit("fs4_dec", 1'b0, fs4_active);
    chk_bit("cfg_dec", 1'b1, config_error);
    spi(1'b0, 15'h0200, 8'h00);
    $display("test config done");
    init_seq;
    $display("test init done");
    stall_en = 1'b1;
    repeat (4) frames(5);
    stall_en = 1'b0;
    frames(5);
    samp_valid = 1'b0;
    repeat (40) @(negedge clk_sys);
    chk_word("frames_left", 64'h0, 64'(exp_q.size()));
    power_down_pin = 1'b1;
    repeat (5) @(negedge clk_sys);
    power_down_pin = 1'b0;
    repeat (6) @(negedge clk_sys);
    chk_bit("reinit_pd", 1'b1, reinit_required);
    $display("test stream done");
    for (int i = 0; i < 4; i++) begin
      spi(1'b0, 15'h0201, dec[i]);
      chk_bit("band_off", 1'b1, band_mismatch);
      spi(1'b0, 15'h056e, band[i]);
      chk_bit("band_on", 1'b0, band_mismatch);
      chk_bit("rate_ok", i < 3, lane_rate_ok);
    end
    $display("test band done");
    for (int i = 0; i < 4; i++) begin
      init_seq;
      spi(1'b0, ea[i], e1[i]);
      spi(1'b0, ea[i], e2[i]);
      chk_bit("reinit_evt", 1'b1, reinit_required);
    end
    spi(1'b1, 15'h0570, 8'h00);
    chk_word("rd_defaults", 64'h0, {56'h0, rd});
    $display("test restart done");
    spi(1'b0, 15'h0570, 8'h0b);
    spi(1'b0, 15'h058f, 8'h0f);
    chk_bit("cfg_l8f2", 1'b0, config_error);
    chk_bit("fs4_off", 1'b0, fs4_active);
    frames(4);
    samp_valid = 1'b0;
    repeat (20) @(negedge clk_sys);
    chk_word("plain_left", 64'h0, 64'(exp_q.size()));
    $display("test plain done");
    test_done;
  end
endmodule // serial_link_setup_framer_tb

bind serial_link_setup_framer link_framer_props props_u (.clk_sys, .rstn, .spi_cs_n, .spi_sdio_oe,
  .power_down_pin, .samp_ready, .lane_valid, .lane_ready, .serial_lane_output, .fs4_active,
  .reinit_required, .config_error);
`default_nettype wire
